// *** hdl/cis_intr_section.v ***
`include "cis_consts.vh"

// ----------------------------------------------------------------
// Interrupt section: request state, prioritizing, microcode access
// ----------------------------------------------------------------
module cis_intr_section (
  input  wire        ref_clk,
  input  wire        reset,
  input  wire [3:0]  deviceRequest,
  input  wire        haltRequest,
  input  wire        systemErrorRequest,
  input  wire        hardErrorEvent,
  input  wire        softErrorEvent,
  input  wire        serialLineEvent,
  input  wire        perfMonitorEvent,
  input  wire        intervalTimerRequest,
  input  wire [4:0]  priorityLevel,
  input  wire        stateWrite,
  input  wire [31:0] writeData,
  input  wire        stateRead,
  output reg  [31:0] operandReadBus,
  output wire        interruptRequest,
  output wire        haltRequestOut,
  output reg  [7:0]  dispatchVector
);

  // --------------------------------------------------------------
  // Synchronized external requests
  // --------------------------------------------------------------
  wire [5:0] extSync;
  wire       hardErrSync;

  cis_sync #(
    .WIDTH(6)
  ) uSync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .asyncIn ({haltRequest, systemErrorRequest, deviceRequest}),
    .syncOut (extSync)
  );

  // --------------------------------------------------------------
  // State register storage
  // --------------------------------------------------------------
  reg  [5:0]  extLevel_q;
  reg         hardErr_q;
  reg         pmon_q;
  reg         softErr_q;
  reg         serial_q;
  reg         timer_q;
  reg  [15:1] swBits_q;
  wire [31:0] reqState;

  assign hardErrSync = hardErr_q;

  // External inputs follow their source level; no acknowledge exists.
  always @(posedge ref_clk) begin
    if (reset) begin
      extLevel_q <= 6'h00;
    end else begin
      extLevel_q <= extSync;
    end
  end

  // Set wins over a same-cycle clear on every set-reset flop.
  always @(posedge ref_clk) begin
    if (reset) begin
      hardErr_q <= 1'b0;
      pmon_q    <= 1'b0;
      softErr_q <= 1'b0;
      serial_q  <= 1'b0;
      timer_q   <= 1'b0;
    end else begin
      if (hardErrorEvent) begin
        hardErr_q <= 1'b1;
      end else if (stateWrite && writeData[`CIS_BIT_SYSERR]) begin
        hardErr_q <= 1'b0;
      end
      if (perfMonitorEvent) begin
        pmon_q <= 1'b1;
      end else if (stateWrite && writeData[`CIS_BIT_PMON]) begin
        pmon_q <= 1'b0;
      end
      if (softErrorEvent) begin
        softErr_q <= 1'b1;
      end else if (stateWrite && writeData[`CIS_BIT_SOFTERR]) begin
        softErr_q <= 1'b0;
      end
      if (serialLineEvent) begin
        serial_q <= 1'b1;
      end else if (stateWrite && writeData[`CIS_BIT_SERIAL]) begin
        serial_q <= 1'b0;
      end
      // The timer flag lives in the timer; only its request is kept.
      if (intervalTimerRequest) begin
        timer_q <= 1'b1;
      end else if (stateWrite && writeData[`CIS_BIT_TIMER]) begin
        timer_q <= 1'b0;
      end
    end
  end

  // Software bits take the written value whole.
  always @(posedge ref_clk) begin
    if (reset) begin
      swBits_q <= 15'h0000;
    end else if (stateWrite) begin
      swBits_q <= writeData[15:1];
    end
  end

  // There is no power-fail position anywhere in this register.
  assign reqState = {extLevel_q[5], serial_q,
                     extLevel_q[4] | hardErrSync,
                     pmon_q, softErr_q,
                     extLevel_q[3], extLevel_q[2], timer_q,
                     extLevel_q[1], extLevel_q[0],
                     6'h00, swBits_q, 1'b0};

  // --------------------------------------------------------------
  // Interrupt generation
  // --------------------------------------------------------------
  wire       anyReq;
  wire [4:0] reqLevel;
  wire [4:0] reqId;
  wire [7:0] reqVector;
  wire       haltWin;
  wire       aboveLevel;
  wire [4:0] readId;

  cis_prio_enc uEnc (
    .reqState  (reqState),
    .anyReq    (anyReq),
    .reqLevel  (reqLevel),
    .reqId     (reqId),
    .reqVector (reqVector),
    .haltWin   (haltWin)
  );

  // Halt ignores the current level, even when it is already 1F.
  assign aboveLevel = anyReq && (reqLevel > priorityLevel);
  assign interruptRequest = aboveLevel || haltWin;
  assign haltRequestOut   = haltWin;

  // A request that dropped away before the read yields a zero ID.
  assign readId = interruptRequest ? reqId : `CIS_ID_NONE;

  // --------------------------------------------------------------
  // Read path; write-one-to-clear fields read back as zero
  // --------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (reset) begin
      operandReadBus <= 32'h00000000;
      dispatchVector <= `CIS_VEC_NONE;
    end else begin
      dispatchVector <= interruptRequest ? reqVector : `CIS_VEC_NONE;
      if (stateRead) begin
        operandReadBus <= {11'h000, readId, swBits_q, 1'b0};
      end else begin
        operandReadBus <= 32'h00000000;
      end
    end
  end

endmodule // cis_intr_section

// *** include/cis_consts.vh ***
`ifndef CIS_CONSTS_VH
`define CIS_CONSTS_VH
// Functional notes
// - Six external inputs are level requests, unacknowledged.
// - Fixed vectors; no vector fetch performed.
// - No power-fail request source exists.
// - Request above current level raises microsequencer request.
// - Halt requests level 1F regardless of level.
// - System error requests level 1D, vector 60.
// - Device inputs 0-3 request levels 14-17.
// - Hard error ORs into system error; soft 1A.
// - Performance monitor requests 1B; cleared by write.
// - Interval timer expiry requests level 16.
// - Software bit n requests level n.
// - Microcode clears software bits by writing them.
// - Fixed priority order from halt to software 1.
// - Device 2 beats interval timer at 16.
// - Interrupt ID read onto operand read bus.
// - External inputs pass a two-stage synchronizer.
// - Internal requests set-reset; others level-held.
// - State register bit positions as listed.
// - No local copy of timer flag.
// - ID reads zero when nothing above level and no halt.
// - ID equals level; timer reports 1C.
// - Writing one to bit 24 clears timer.

// ----------------------------------------------------------------
// State register bit positions
// ----------------------------------------------------------------
`define CIS_BIT_HALT    31
`define CIS_BIT_SERIAL  30
`define CIS_BIT_SYSERR  29
`define CIS_BIT_PMON    28
`define CIS_BIT_SOFTERR 27
`define CIS_BIT_DEV3    26
`define CIS_BIT_DEV2    25
`define CIS_BIT_TIMER   24
`define CIS_BIT_DEV1    23
`define CIS_BIT_DEV0    22
`define CIS_ID_LSB      16
`define CIS_ID_MSB      20

// ----------------------------------------------------------------
// Request levels and interrupt IDs
// ----------------------------------------------------------------
`define CIS_LVL_HALT    5'h1f
`define CIS_LVL_SYSERR  5'h1d
`define CIS_LVL_PMON    5'h1b
`define CIS_LVL_SOFTERR 5'h1a
`define CIS_LVL_SERIAL  5'h18
`define CIS_LVL_DEV3    5'h17
`define CIS_LVL_DEV2    5'h16
`define CIS_LVL_TIMER   5'h16
`define CIS_ID_TIMER    5'h1c
`define CIS_LVL_DEV1    5'h15
`define CIS_LVL_DEV0    5'h14
`define CIS_ID_NONE     5'h00

// ----------------------------------------------------------------
// Vector offsets
// ----------------------------------------------------------------
`define CIS_VEC_NONE    8'h00
`define CIS_VEC_SYSERR  8'h60
`define CIS_VEC_SOFTERR 8'h54
`define CIS_VEC_TIMER   8'hc0
`define CIS_VEC_DEV0    8'hd0
`define CIS_VEC_SW1     8'h84
`define CIS_SYNC_STAGES 2
`endif

// *** hdl/cis_sync.v ***
`include "cis_consts.vh"

// Two-flop synchronizer for a bank of asynchronous level inputs.
module cis_sync #(
  parameter WIDTH = 6
) (
  input  wire             ref_clk,
  input  wire             reset,
  input  wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] stable_q;

  always @(posedge ref_clk) begin
    if (reset) begin
      meta_q   <= {WIDTH{1'b0}};
      stable_q <= {WIDTH{1'b0}};
    end else begin
      meta_q   <= asyncIn;
      stable_q <= meta_q;
    end
  end

  assign syncOut = stable_q;

endmodule // cis_sync

// *** hdl/cis_prio_enc.v ***
`include "cis_consts.vh"

// Priority encoder over the state register request bits.
module cis_prio_enc (
  input  wire [31:0] reqState,
  output reg         anyReq,
  output reg  [4:0]  reqLevel,
  output reg  [4:0]  reqId,
  output reg  [7:0]  reqVector,
  output reg         haltWin
);

  integer i;

  always @* begin
    anyReq    = 1'b1;
    haltWin   = 1'b0;
    reqLevel  = `CIS_ID_NONE;
    reqId     = `CIS_ID_NONE;
    reqVector = `CIS_VEC_NONE;
    // Highest first; device 2 is tested before the timer.
    if (reqState[`CIS_BIT_HALT]) begin
      reqLevel = `CIS_LVL_HALT;
      haltWin  = 1'b1;
    end else if (reqState[`CIS_BIT_SYSERR]) begin
      reqLevel  = `CIS_LVL_SYSERR;
      reqVector = `CIS_VEC_SYSERR;
    end else if (reqState[`CIS_BIT_PMON]) begin
      reqLevel = `CIS_LVL_PMON;
    end else if (reqState[`CIS_BIT_SOFTERR]) begin
      reqLevel  = `CIS_LVL_SOFTERR;
      reqVector = `CIS_VEC_SOFTERR;
    end else if (reqState[`CIS_BIT_SERIAL]) begin
      reqLevel = `CIS_LVL_SERIAL;
    end else if (reqState[`CIS_BIT_DEV3]) begin
      reqLevel  = `CIS_LVL_DEV3;
      reqVector = `CIS_VEC_DEV0 + 8'h0c;
    end else if (reqState[`CIS_BIT_DEV2]) begin
      reqLevel  = `CIS_LVL_DEV2;
      reqVector = `CIS_VEC_DEV0 + 8'h08;
    end else if (reqState[`CIS_BIT_TIMER]) begin
      reqLevel  = `CIS_LVL_TIMER;
      reqVector = `CIS_VEC_TIMER;
    end else if (reqState[`CIS_BIT_DEV1]) begin
      reqLevel  = `CIS_LVL_DEV1;
      reqVector = `CIS_VEC_DEV0 + 8'h04;
    end else if (reqState[`CIS_BIT_DEV0]) begin
      reqLevel  = `CIS_LVL_DEV0;
      reqVector = `CIS_VEC_DEV0;
    end else begin
      anyReq = 1'b0;
      for (i = 1; i <= 15; i = i + 1) begin
        if (reqState[i]) begin
          anyReq    = 1'b1;
          reqLevel  = i[4:0];
          reqVector = `CIS_VEC_SW1 + {i[5:0] - 6'd1, 2'b00};
        end
      end
    end
    // Fixed vectors only; the ID equals the level except for the timer.
    reqId = reqLevel;
    if (anyReq && reqLevel == `CIS_LVL_TIMER &&
        !reqState[`CIS_BIT_DEV2]) begin
      reqId = `CIS_ID_TIMER;
    end
  end

endmodule // cis_prio_enc

// *** sim/cis_src_model.sv ***
// ----------------------------------------------------------------
// External request sources: halt, system error, devices 3..0
// ----------------------------------------------------------------
module cis_src_model (
  input  wire logic       ref_clk,
  input  wire logic [5:0] raiseReq,
  input  wire logic [5:0] ackReq,
  output logic      [5:0] srcLevel
);
  timeunit 1ns;
  timeprecision 1ns;
  initial srcLevel = 6'h00;
  // A source holds its line high until its handler acknowledges it.
  always @(posedge ref_clk) begin
    srcLevel <= (srcLevel | raiseReq) & ~ackReq;
  end
endmodule // cis_src_model

// *** sim/cis_intr_checker.sv ***
module cis_intr_checker (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic [3:0]  deviceRequest,
  input wire logic        haltRequest,
  input wire logic        systemErrorRequest,
  input wire logic [4:0]  priorityLevel,
  input wire logic        stateRead,
  input wire logic [31:0] operandReadBus,
  input wire logic        interruptRequest,
  input wire logic        haltRequestOut,
  input wire logic [7:0]  dispatchVector
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  chk_halt_ungated: assert property
    (haltRequest [*4] |-> interruptRequest)
    else $error("held halt raised no request");
  chk_halt_level: assert property
    (haltRequest [*4] |-> haltRequestOut)
    else $error("held halt not seen");
  chk_sync_delay: assert property
    ((!haltRequest) [*4] ##1 haltRequest |-> (!haltRequestOut) [*3])
    else $error("halt passed too early");
  chk_dev_raise: assert property
    ((deviceRequest[0] && priorityLevel < 5'h14) [*4] |-> interruptRequest)
    else $error("device request not raised");
  chk_syserr_raise: assert property
    ((systemErrorRequest && priorityLevel < 5'h1d) [*4] |-> interruptRequest)
    else $error("system error not raised");
  chk_syserr_vec: assert property
    ((systemErrorRequest && !haltRequest && priorityLevel < 5'h1d) [*6]
      |-> dispatchVector == 8'h60)
    else $error("system error vector wrong");
  chk_bus_idle: assert property
    (!$past(stateRead) |-> operandReadBus == 32'h0)
    else $error("read bus driven without read");
  chk_bus_fixed: assert property
    (operandReadBus[31:21] == 11'h0 && operandReadBus[0] == 1'b0)
    else $error("fixed read bits not zero");
  chk_id_zero: assert property
    ($past(stateRead) && !$past(interruptRequest)
      |-> operandReadBus[20:16] == 5'h00)
    else $error("id not zero without request");
  chk_id_given: assert property
    ($past(stateRead) && $past(interruptRequest)
      |-> operandReadBus[20:16] != 5'h00)
    else $error("id zero with request");
  cov_halt: cover property (haltRequestOut);
  cov_timer: cover property (stateRead ##1 operandReadBus[20:16] == 5'h1c);
  cov_gated: cover property (!interruptRequest && priorityLevel == 5'h0f);
endmodule // cis_intr_checker

// *** sim/tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk = 0;
  logic        reset = 1;
  logic [5:0]  raise = 0;
  logic [5:0]  ack = 0;
  wire  [5:0]  srcLevel;
  logic [4:0]  hwEv = 0;
  logic [4:0]  priorityLevel = 0;
  logic        stateWrite = 0;
  logic        stateRead = 0;
  logic [31:0] writeData = 0;
  logic [14:0] swExp = 0;
  wire  [31:0] operandReadBus;
  wire         interruptRequest;
  wire         haltRequestOut;
  wire  [7:0]  dispatchVector;
  int          bad_count = 0;
  int          n_tests = 0;
  int          cyc = 0;
  always #50 ref_clk = ~ref_clk;
  cis_src_model src_i (.ref_clk(ref_clk), .raiseReq(raise), .ackReq(ack),
    .srcLevel(srcLevel));
  cis_intr_section uut (
    .ref_clk(ref_clk), .reset(reset), .deviceRequest(srcLevel[3:0]),
    .haltRequest(srcLevel[4]), .systemErrorRequest(srcLevel[5]),
    .hardErrorEvent(hwEv[4]), .softErrorEvent(hwEv[3]),
    .serialLineEvent(hwEv[2]), .perfMonitorEvent(hwEv[1]),
    .intervalTimerRequest(hwEv[0]), .priorityLevel(priorityLevel),
    .stateWrite(stateWrite), .writeData(writeData), .stateRead(stateRead),
    .operandReadBus(operandReadBus), .interruptRequest(interruptRequest),
    .haltRequestOut(haltRequestOut), .dispatchVector(dispatchVector));
  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    if (bad_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic wr(input logic [31:0] v);
    @(negedge ref_clk);
    stateWrite = 1;
    writeData = v;
    @(negedge ref_clk);
    stateWrite = 0;
    tick(3);
  endtask
  task automatic rd(input logic [4:0] id, input logic [7:0] vec);
    @(negedge ref_clk);
    stateRead = 1;
    @(negedge ref_clk);
    stateRead = 0;
    chk(operandReadBus, {11'h0, id, swExp, 1'b0});
    if (id != 0) chk(dispatchVector, vec);
  endtask
  task automatic src(input logic [5:0] r, input logic [5:0] a);
    @(negedge ref_clk);
    raise = r;
    ack = a;
    @(negedge ref_clk);
    raise = 0;
    ack = 0;
    tick(5);
  endtask
  task automatic ev(input logic [4:0] m);
    @(negedge ref_clk);
    hwEv = m;
    @(negedge ref_clk);
    hwEv = 0;
    tick(2);
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 3000) begin
      bad_count++;
      report_and_stop;
    end
  end
  initial begin
    tick(3);
    reset = 0;
    for (int i = 0; i < 4; i++) begin
      src(6'h1 << i, 0);
      chk(interruptRequest, 1);
      rd(5'h14 + i, 8'hd0 + 4 * i);
      src(0, 6'h1 << i);
      rd(0, 0);
    end
    src(6'h04, 0);
    ev(5'h01);
    rd(5'h16, 8'hd8);
    src(0, 6'h04);
    wr(32'h0);
    rd(5'h1c, 8'hc0);
    wr(32'h0100_0000);
    rd(0, 0);
    ev(5'h0e);
    rd(5'h1b, 8'h00);
    wr(32'h1000_0000);
    rd(5'h1a, 8'h54);
    wr(32'h0800_0000);
    rd(5'h18, 8'h00);
    wr(32'h4000_0000);
    rd(0, 0);
    ev(5'h10);
    rd(5'h1d, 8'h60);
    wr(32'h2000_0000);
    rd(0, 0);
    src(6'h21, 0);
    rd(5'h1d, 8'h60);
    src(0, 6'h20);
    rd(5'h14, 8'hd0);
    src(0, 6'h01);
    for (int n = 1; n < 16; n++) begin
      swExp = 15'h1 << (n - 1);
      wr({16'h0, swExp, 1'b0});
      rd(n, 8'h84 + 4 * (n - 1));
    end
    priorityLevel = 5'h0f;
    tick(1);
    chk(interruptRequest, 0);
    rd(0, 0);
    priorityLevel = 5'h0e;
    tick(1);
    chk(interruptRequest, 1);
    swExp = 0;
    wr(0);
    rd(0, 0);
    priorityLevel = 5'h1f;
    src(6'h10, 0);
    chk({interruptRequest, haltRequestOut}, 2'b11);
    rd(5'h1f, 8'h00);
    src(0, 6'h10);
    report_and_stop;
  end
endmodule // tb_top
bind cis_intr_section cis_intr_checker chk_i (
  .ref_clk(ref_clk), .reset(reset), .deviceRequest(deviceRequest),
  .haltRequest(haltRequest), .systemErrorRequest(systemErrorRequest),
  .priorityLevel(priorityLevel), .stateRead(stateRead),
  .operandReadBus(operandReadBus), .interruptRequest(interruptRequest),
  .haltRequestOut(haltRequestOut), .dispatchVector(dispatchVector));
